// *** hdl/sysctl_pkg.sv ***
// system control package: sfr map, field positions, reset values, state types
// assumes one oscillator-rate clock and sfr accesses from the core
package sysctl_pkg;
  // sfr addresses
  localparam logic [7:0] PWR_ADDR = 8'h87;
  localparam logic [7:0] AUX_ADDR = 8'h8e;
  localparam logic [7:0] WDOG_ADDR = 8'h8f;
  // power control fields
  localparam int PC_DOZE = 0;
  localparam int PC_PDOWN = 1;
  localparam int PC_GF0 = 2;
  localparam int PC_COLD = 4;
  // aux control fields
  localparam int AUX_SUPP = 0;
  // watchdog control fields
  localparam int WD_PS0 = 0;
  localparam int WD_DOZE_RUN = 5;
  localparam int WD_CLR = 6;
  localparam int WD_EN = 7;
  // reset values
  localparam logic [7:0] SFR_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] SP_RST = 8'h07;
  // timing: oscillator at 40 MHz, 12 oscillator periods per machine cycle
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [3:0] MC_LAST = 4'hb;
  // state 5 phase 2 is oscillator period 9 of the machine cycle
  localparam logic [3:0] PHASE_IDX = 4'h9;
  localparam logic [1:0] RST_MC_MIN = 2'h2;
  localparam logic [13:0] WCNT_LAST = 14'h3fff;
  // reset sampler state
  typedef struct packed {
    logic [1:0] cnt;
    logic hold;
  } smp_t;
  // sfr access from the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  // control state
  typedef struct packed {
    logic [3:0] osc_cnt;
    logic cold;
    logic [1:0] gf;
    logic pdown;
    logic doze;
    logic supp;
    logic wen;
    logic wclr;
    logic doze_run;
    logic [2:0] ps;
    logic [7:0] pre;
    logic [13:0] wcnt;
    logic wdt_rst;
    logic srst;
    logic ale;
    logic gain_half;
    logic [7:0] rdata;
  } ctl_t;
endpackage : sysctl_pkg

// *** hdl/reset_sampler.sv ***
// reset pin sampler: counts consecutive high samples at the sampling strobe
// assumes the pin is already synchronous to i_clk
module reset_sampler #(
  parameter logic [1:0] MIN_SAMPLES = 2'h2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // sampling
  input wire logic i_strobe,
  input wire logic i_pin,
  // filtered reset level
  output logic o_hold
);
  sysctl_pkg::smp_t q;
  sysctl_pkg::smp_t d;

  // a low sample restarts the count, so a short glitch never reaches the hold
  always_comb
  begin
    d = q;
    if (i_strobe)
    begin
      if (!i_pin)
      begin
        d.cnt = 2'h0;
        d.hold = 1'b0;
      end
      else if (q.cnt != MIN_SAMPLES)
      begin
        d.cnt = q.cnt + 2'h1;
        d.hold = (q.cnt + 2'h1) == MIN_SAMPLES;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  assign o_hold = q.hold;
endmodule : reset_sampler

// *** hdl/sysctl_watchdog.sv ***
// watchdog, power control, reset sampling and address strobe control
// assumes the core issues single-cycle sfr writes and reads the data one cycle later
module sysctl_watchdog (
  // clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst,
  // external reset pin
  input wire logic i_rst_pin,
  // sfr access from the core
  input wire sysctl_pkg::sfr_req_t i_sfr,
  output logic o_sfr_sel,
  output logic [7:0] o_sfr_rdata,
  // core events
  input wire logic i_irq,
  input wire logic i_ext_access,
  input wire logic i_ale_core,
  input wire logic i_sec_b7,
  // clock, reset and address strobe control
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_osc_run,
  output logic o_sys_reset,
  output logic o_ale,
  output logic o_osc_gain_half
);
  sysctl_pkg::ctl_t q;
  sysctl_pkg::ctl_t d;
  logic mc_tick;
  logic state5_phase2;
  logic rst_hold;
  logic run;
  logic [3:0] ratio_exp;
  logic [7:0] pre_lim;
  logic pre_wrap;
  logic [7:0] watchdog_control_val;
  logic [7:0] power_control_val;

  // machine cycle timing from the oscillator count
  assign mc_tick = q.osc_cnt == sysctl_pkg::MC_LAST;
  assign state5_phase2 = q.osc_cnt == sysctl_pkg::PHASE_IDX;

  // two consecutive samples needed, one machine cycle apart
  reset_sampler #(
    .MIN_SAMPLES(sysctl_pkg::RST_MC_MIN)
  ) u_rst_smp (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_strobe(state5_phase2),
    .i_pin(i_rst_pin),
    .o_hold(rst_hold)
  );

  // low codes swap the two lower select bits; codes with the top bit set count plainly
  assign ratio_exp = q.ps[2] ? ({1'b0, q.ps} + 4'h1)
    : ({2'h0, q.ps[0], q.ps[1]} + 4'h1);
  assign pre_lim = 8'((9'h1 << ratio_exp) - 9'h1);
  assign pre_wrap = q.pre == pre_lim;
  // doze stops the count unless the idle-run bit is set; power-down always
  assign run = q.wen && !q.pdown && (!q.doze || q.doze_run);

  // read views of the registers
  assign watchdog_control_val = {q.wen, q.wclr, q.doze_run, 2'h0, q.ps};
  assign power_control_val = {3'h0, q.cold, q.gf, q.pdown, q.doze};

  // next state
  always_comb
  begin
    d = q;
    d.osc_cnt = mc_tick ? 4'h0 : q.osc_cnt + 4'h1;
    d.wdt_rst = 1'b0;
    // the prescaler advances once per machine cycle, 12 oscillator periods
    if (mc_tick && !q.pdown)
    begin
      if (q.wclr)
      begin
        d.pre = 8'h00;
        d.wcnt = 14'h0000;
        d.wclr = 1'b0;
      end
      else if (run)
      begin
        d.pre = pre_wrap ? 8'h00 : q.pre + 8'h01;
        if (pre_wrap)
        begin
          d.wcnt = q.wcnt + 14'h0001;
          d.wdt_rst = q.wcnt == sysctl_pkg::WCNT_LAST;
        end
      end
    end
    // sfr writes; a write of one to the clear bit wins over its self-clear
    if (i_sfr.wr)
    begin
      case (i_sfr.addr)
        sysctl_pkg::WDOG_ADDR:
        begin
          d.wen = i_sfr.wdata[sysctl_pkg::WD_EN];
          d.wclr = q.wclr | i_sfr.wdata[sysctl_pkg::WD_CLR];
          d.doze_run = i_sfr.wdata[sysctl_pkg::WD_DOZE_RUN];
          d.ps = i_sfr.wdata[sysctl_pkg::WD_PS0 +: 3];
        end
        sysctl_pkg::PWR_ADDR:
        begin
          d.cold = q.cold & i_sfr.wdata[sysctl_pkg::PC_COLD];
          d.gf = i_sfr.wdata[sysctl_pkg::PC_GF0 +: 2];
          d.pdown = i_sfr.wdata[sysctl_pkg::PC_PDOWN];
          d.doze = i_sfr.wdata[sysctl_pkg::PC_DOZE];
        end
        sysctl_pkg::AUX_ADDR:
        begin
          d.supp = i_sfr.wdata[sysctl_pkg::AUX_SUPP];
        end
        default:
        begin
          d.supp = q.supp;
        end
      endcase
    end
    // any interrupt wakes the core from doze
    if (q.doze && i_irq)
      d.doze = 1'b0;
    // read data registered from the addressed sfr
    case (i_sfr.addr)
      sysctl_pkg::WDOG_ADDR: d.rdata = watchdog_control_val;
      sysctl_pkg::PWR_ADDR: d.rdata = power_control_val;
      sysctl_pkg::AUX_ADDR: d.rdata = {7'h00, q.supp};
      default: d.rdata = 8'h00;
    endcase
    // strobe follows the core except when suppressed and access is internal
    d.ale = (q.supp && !i_ext_access) ? 1'b0 : i_ale_core;
    d.gain_half = !i_sec_b7;
    // system reset from the pin filter or a watchdog time-out
    d.srst = rst_hold || q.wdt_rst;
    // system reset clears the sfr fields except the cold-boot flag, and the watchdog counts
    if (q.srst)
    begin
      d.gf = 2'h0;
      d.pdown = 1'b0;
      d.doze = 1'b0;
      d.supp = sysctl_pkg::SFR_RST[sysctl_pkg::AUX_SUPP];
      d.wen = 1'b0;
      d.wclr = 1'b0;
      d.doze_run = 1'b0;
      d.ps = 3'h0;
      d.pre = 8'h00;
      d.wcnt = 14'h0000;
      d.wdt_rst = 1'b0;
    end
  end

  // state register; power-on reset alone sets the cold-boot flag
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q <= '0;
      q.cold <= 1'b1;
      q.ale <= 1'b1;
    end
    else
      q <= d;
  end

  // outputs; the core runs on odd oscillator periods, i.e. the clock halved
  assign o_cpu_clk_en = q.osc_cnt[0] && !q.doze && !q.pdown;
  assign o_periph_clk_en = q.osc_cnt[0] && !q.pdown;
  assign o_osc_run = !q.pdown;
  assign o_sys_reset = q.srst;
  assign o_ale = q.ale;
  assign o_osc_gain_half = q.gain_half;
  assign o_sfr_rdata = q.rdata;
  assign o_sfr_sel = i_sfr.addr == sysctl_pkg::WDOG_ADDR || i_sfr.addr == sysctl_pkg::PWR_ADDR
    || i_sfr.addr == sysctl_pkg::AUX_ADDR;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_timeout_reset;
    q.wdt_rst |=> o_sys_reset ##1 (!q.wen && q.wcnt == 14'h0000);
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("no reset after time-out");

  property p_reset_clears;
    o_sys_reset |=> (!q.wen && q.pre == 8'h00 && q.wcnt == 14'h0000);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("watchdog left set by reset");

  property p_no_count_off;
    (!q.wen && !o_sys_reset && !q.wclr) |=> $stable(q.wcnt);
  endproperty
  a_no_count_off: assert property (p_no_count_off) else $error("count while disabled");

  property p_clear_self;
    (q.wclr && mc_tick && !q.pdown && !i_sfr.wr) |=> (!q.wclr && q.wcnt == 14'h0000);
  endproperty
  a_clear_self: assert property (p_clear_self) else $error("clear bit not applied");

  property p_idle_stop;
    (q.doze && !q.doze_run && !o_sys_reset && !q.wclr) |=> $stable(q.pre);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("watchdog ran in doze");

  property p_pd_freeze;
    (q.pdown && !o_sys_reset) |=> ($stable(q.wcnt) && !o_cpu_clk_en && !o_periph_clk_en);
  endproperty
  a_pd_freeze: assert property (p_pd_freeze) else $error("clocks ran in power-down");

  property p_wake;
    (q.doze && i_irq) |=> !q.doze ##0 $past(q.osc_cnt) != 4'hf;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not end doze");

  property p_ale_off;
    (q.supp && !i_ext_access && !o_sys_reset) |=> !o_ale;
  endproperty
  a_ale_off: assert property (p_ale_off) else $error("strobe not suppressed");

  property p_ale_ext;
    i_ext_access |=> o_ale == $past(i_ale_core);
  endproperty
  a_ale_ext: assert property (p_ale_ext) else $error("strobe lost on external access");

  property p_glitch;
    (state5_phase2 && !i_rst_pin && !q.wdt_rst) |=> ##1 !o_sys_reset [*2];
  endproperty
  a_glitch: assert property (p_glitch) else $error("reset from a short pulse");

  property p_gain;
    !i_sec_b7 |=> o_osc_gain_half;
  endproperty
  a_gain: assert property (p_gain) else $error("gain not halved");
endmodule : sysctl_watchdog

// *** dv/core_model.sv ***
// core model: issues sfr writes and reads the way the processor core does
// assumes the block takes writes at posedge and answers reads one cycle later
module core_model (
  // clock
  input wire logic i_clk,
  // sfr access to the block
  output sysctl_pkg::sfr_req_t o_sfr,
  input wire logic [7:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // park on an unmapped address so stale read data never looks valid
  initial o_sfr = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};
  // one-cycle write strobe; data scrambled afterwards so it cannot linger
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_sfr = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge i_clk);
    o_sfr.wr = 1'b0;
    o_sfr.wdata = ~d;
  endtask : write
  // address held across one edge, data taken once it has settled
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_sfr = '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge i_clk);
    d = i_rdata;
  endtask : read
endmodule : core_model

// *** dv/sysctl_watchdog_tb.sv ***
// bench for the system control block: sfr tasks plus pin and event stimulus
// assumes the core model above and the package constants
module sysctl_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_pin = 1'b0;
  logic irq = 1'b0;
  logic ext_acc = 1'b0;
  logic ale_core = 1'b0;
  logic sec_b7 = 1'b1;
  sysctl_pkg::sfr_req_t sfr;
  logic sel, cpu_en, per_en, osc_run, sys_rst, ale, gain_half;
  logic [7:0] rdata, rd, seen;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  sysctl_watchdog dut_u (.i_clk(clk), .i_rst(rst), .i_rst_pin(rst_pin), .i_sfr(sfr),
    .o_sfr_sel(sel), .o_sfr_rdata(rdata), .i_irq(irq), .i_ext_access(ext_acc),
    .i_ale_core(ale_core), .i_sec_b7(sec_b7), .o_cpu_clk_en(cpu_en),
    .o_periph_clk_en(per_en), .o_osc_run(osc_run), .o_sys_reset(sys_rst), .o_ale(ale),
    .o_osc_gain_half(gain_half));

  core_model core_u (.i_clk(clk), .o_sfr(sfr), .i_rdata(rdata));

  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    core_u.read(a, rd);
    chk(name, exp, rd);
  endtask : rchk

  // or-collect core enable, peripheral enable and system reset over n cycles
  task automatic watch(input int n);
    seen = 8'h00;
    repeat (n)
    begin
      @(negedge clk);
      seen = seen | {5'h00, sys_rst, per_en, cpu_en};
    end
  endtask : watch

  // hang guard: the whole sequence needs under 1500 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      complete_run();
    end
  end

  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rchk("power_control", sysctl_pkg::PWR_ADDR, 8'h10);
    rchk("aux_control", sysctl_pkg::AUX_ADDR, 8'h00);
    rchk("watchdog_control", sysctl_pkg::WDOG_ADDR, 8'h00);
    rchk("unmapped", 8'h80, 8'h00);
    chk("o_sfr_sel", 8'h00, {7'h00, sel});
    // the cold-boot bit is written as one so the flag survives this write
    core_u.write(sysctl_pkg::PWR_ADDR, 8'h1c);
    rchk("user_flags", sysctl_pkg::PWR_ADDR, 8'h1c);
    core_u.write(sysctl_pkg::PWR_ADDR, 8'h00);
    rchk("cold_boot_flag", sysctl_pkg::PWR_ADDR, 8'h00);
    sec_b7 = 1'b0;
    repeat (2) @(negedge clk);
    chk("o_osc_gain_half", 8'h01, {7'h00, gain_half});
    // strobe: held low while suppressed, follows the core during external access
    core_u.write(sysctl_pkg::AUX_ADDR, 8'h01);
    repeat (3) @(negedge clk);
    rd = {7'h00, ale};
    ale_core = 1'b1;
    repeat (3) @(negedge clk);
    chk("o_ale frozen", rd, {7'h00, ale});
    ext_acc = 1'b1;
    repeat (3) @(negedge clk);
    chk("o_ale ext high", 8'h01, {7'h00, ale});
    ale_core = 1'b0;
    repeat (3) @(negedge clk);
    chk("o_ale ext low", 8'h00, {7'h00, ale});
    ext_acc = 1'b0;
    repeat (3) @(negedge clk);
    rd = {7'h00, ale};
    ale_core = 1'b1;
    repeat (3) @(negedge clk);
    chk("o_ale refrozen", rd, {7'h00, ale});
    // doze keeps peripherals clocked, an interrupt wakes the core
    core_u.write(sysctl_pkg::PWR_ADDR, 8'h01);
    watch(24);
    chk("doze enables", 8'h02, seen);
    irq = 1'b1;
    watch(24);
    chk("wake enables", 8'h03, seen);
    irq = 1'b0;
    // every prescale code is stored; the clear bit drops by itself
    for (int ps = 0; ps < 8; ps++)
    begin
      core_u.write(sysctl_pkg::WDOG_ADDR, {5'h14, ps[2:0]});
      rchk("prescale_select", sysctl_pkg::WDOG_ADDR, {5'h14, ps[2:0]});
    end
    core_u.write(sysctl_pkg::WDOG_ADDR, 8'he7);
    repeat (24) @(negedge clk);
    rchk("wdog_clear", sysctl_pkg::WDOG_ADDR, 8'ha7);
    // code 101 divides by 64: one count per 768 clocks, so 96 machine cycles give one
    core_u.write(sysctl_pkg::WDOG_ADDR, 8'hc5);
    repeat (1164) @(negedge clk);
    chk("wdog count ratio 64", 8'h01, dut_u.q.wcnt[7:0]);
    // short pin pulse sees at most one sample and must not reset
    core_u.write(sysctl_pkg::PWR_ADDR, 8'h0e);
    repeat (2) @(negedge clk);
    chk("o_osc_run pd", 8'h00, {7'h00, osc_run});
    rst_pin = 1'b1;
    repeat (6) @(negedge clk);
    rst_pin = 1'b0;
    watch(40);
    chk("glitch", 8'h00, seen & 8'h04);
    // held pin resets the system and ends power-down
    rst_pin = 1'b1;
    watch(48);
    chk("pin reset", 8'h04, seen & 8'h04);
    rst_pin = 1'b0;
    repeat (40) @(negedge clk);
    chk("o_sys_reset", 8'h00, {7'h00, sys_rst});
    chk("o_osc_run", 8'h01, {7'h00, osc_run});
    rchk("power_control rst", sysctl_pkg::PWR_ADDR, 8'h00);
    rchk("watchdog_control rst", sysctl_pkg::WDOG_ADDR, 8'h00);
    complete_run();
  end
endmodule : sysctl_watchdog_tb
